// ==== quad_dac_pkg.sv ====
// constants, field layouts and carriers for the quad converter serial load control
// assumes a single system clock domain; link pins arrive unsynchronised
package quad_dac_pkg;

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LEN = 5'd24;
  localparam logic [4:0] COUNT_MAX = 5'd25;
  localparam logic [23:0] NO_OPERATION_FRAME = 24'h18_0000;
  localparam logic [2:0] ADDR_ALL = 3'h4;
  localparam logic [2:0] CTRL_NOP = 3'h0;
  localparam logic [2:0] CTRL_CONFIG = 3'h1;
  localparam logic [2:0] CTRL_CLEAR = 3'h4;
  localparam int CFG_SDO_OFF_POS = 0;
  localparam int CFG_CLEAR_SEL_POS = 2;
  localparam logic [2:0] RANGE_BIPOLAR_MIN = 3'h3;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;

  typedef enum logic [2:0] {
    REG_DAC = 3'b000,
    REG_RANGE = 3'b001,
    REG_POWER = 3'b010,
    REG_CTRL = 3'b011
  } reg_sel_e;

  typedef struct packed {
    logic readNotWrite;
    logic reservedBit;
    reg_sel_e registerSelectBits;
    logic [2:0] channelAddressBits;
    logic [15:0] dataFieldBits;
  } frame_s;

  // ----------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int PIN_W = 6;
  localparam int PIN_SYNC = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SERIAL_DATA_IN = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_CLEAR = 4;
  localparam int PIN_CODING = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h1B;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] OFF_LINK_CFG = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_POWER = 12'h008;
  localparam logic [11:0] OFF_RANGE = 12'h00C;
  localparam logic [11:0] OFF_DAC0 = 12'h010;
  localparam logic [11:0] OFF_DAC3 = 12'h01C;
  localparam int CFG_CHAIN_POS = 0;
  localparam int ST_SHORT_POS = 0;
  localparam int ST_LONG_POS = 1;
  localparam int ST_CLEAR_POS = 2;
  localparam int ST_READ_POS = 3;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

endpackage : quad_dac_pkg

// ==== quad_dac_serial_load_control.sv ====
// serial write, daisy chain, readback and output update logic of a quad converter
// assumes link pins are asynchronous to sys_clk and the serial clock is at least
// four sys_clk periods per half cycle; apb master on sys_clk
//
// Functional notes
// - frame starts at select fall, 24 edges
// - early select rise discards the frame
// - over 24 edges standalone discards frame
// - select rise moves word into register
// - extra bits leave on serial output
// - serial output changes on rising clock
// - select high latches, stops shifting
// - read bit set arms register readback
// - next frame shifts out selected register
// - disabled serial output enabled during read
// - load low: addressed channel at select rise
// - load high: all channels on load fall
// - clear pin forces zero or midscale
// - clear blocks updates, value then holds
// - control clear command clears too
// - reset zeroes all but the pin synchronisers, channels powered down
// - data writes to powered-down channels ignored
// - bipolar twos complement converted, unipolar straight
// - msb first: rw, reg, channel, data
`timescale 1ns/1ps
module quad_dac_serial_load_control #(
  parameter int CHANNELS = 4,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic frameSelectN,
  input wire logic serialClk,
  input wire logic serialDataIn,
  input wire logic loadOutputsN,
  input wire logic outputClearN,
  input wire logic codingSelectPin,
  input wire quad_dac_pkg::apb_req_s apbReq,
  output quad_dac_pkg::apb_rsp_s apbRsp,
  output logic serialDataOut,
  output logic serialDataOutEn,
  output logic [CHANNELS-1:0][DATA_W-1:0] dacCode,
  output logic [CHANNELS-1:0] channelPowered,
  output logic [CHANNELS-1:0][2:0] channelRange
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic chanHit(input logic [2:0] addr, input int ch);
    chanHit = (addr == quad_dac_pkg::ADDR_ALL) || (addr == 3'(ch));
  endfunction : chanHit

  // twos complement input is stored as offset binary so one clear code fits every range
  function automatic logic [DATA_W-1:0] toStored(input logic [DATA_W-1:0] code,
                                                 input logic [2:0] range,
                                                 input logic twos);
    logic bipolar;
    bipolar = (range >= quad_dac_pkg::RANGE_BIPOLAR_MIN);
    toStored = (bipolar && twos) ? {~code[DATA_W-1], code[DATA_W-2:0]} : code;
  endfunction : toStored

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [quad_dac_pkg::PIN_W-1:0] pinRaw;
  logic [quad_dac_pkg::PIN_W-1:0] pinS1_r;
  logic [quad_dac_pkg::PIN_W-1:0] pinS2_r;
  logic [quad_dac_pkg::PIN_W-1:0] pinS3_r;

  assign pinRaw = {codingSelectPin, outputClearN, loadOutputsN, serialDataIn, serialClk,
                   frameSelectN};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinS1_r <= quad_dac_pkg::PIN_RST;
      pinS2_r <= quad_dac_pkg::PIN_RST;
      pinS3_r <= quad_dac_pkg::PIN_RST;
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  logic selLow;
  logic frameStart;
  logic frameEnd;
  logic sclkFall;
  logic sclkRise;
  logic loadFall;
  logic loadLow;
  logic clearPinLow;
  logic twosSel;

  assign selLow = ~pinS2_r[quad_dac_pkg::PIN_SYNC];
  assign frameStart = pinS3_r[quad_dac_pkg::PIN_SYNC] & ~pinS2_r[quad_dac_pkg::PIN_SYNC];
  assign frameEnd = ~pinS3_r[quad_dac_pkg::PIN_SYNC] & pinS2_r[quad_dac_pkg::PIN_SYNC];
  assign sclkFall = pinS3_r[quad_dac_pkg::PIN_SCLK] & ~pinS2_r[quad_dac_pkg::PIN_SCLK];
  assign sclkRise = ~pinS3_r[quad_dac_pkg::PIN_SCLK] & pinS2_r[quad_dac_pkg::PIN_SCLK];
  assign loadFall = pinS3_r[quad_dac_pkg::PIN_LOAD] & ~pinS2_r[quad_dac_pkg::PIN_LOAD];
  assign loadLow = ~pinS2_r[quad_dac_pkg::PIN_LOAD];
  assign clearPinLow = ~pinS2_r[quad_dac_pkg::PIN_CLEAR];
  assign twosSel = pinS2_r[quad_dac_pkg::PIN_CODING];

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [quad_dac_pkg::FRAME_BITS-1:0] shift_r;
  logic [4:0] bitCount_r;
  logic sdo_r;
  logic sdoEn_r;
  logic readOut_r;
  logic chainMode_r;
  logic badShort_r;
  logic badLong_r;
  logic [DATA_W-1:0] inputReg_r [CHANNELS];
  logic [DATA_W-1:0] dacReg_r [CHANNELS];
  logic [CHANNELS-1:0] powered_r;
  logic [2:0] range_r [CHANNELS];
  logic sdoOff_r;
  logic clearSel_r;

  quad_dac_pkg::frame_s frame;
  logic frameValid;
  logic frameShort;
  logic frameLong;
  logic writeFrame;
  logic readArm;
  logic clearCmd;
  logic clearing;
  logic [DATA_W-1:0] clearCode;
  logic [DATA_W-1:0] readWord;

  assign frame = quad_dac_pkg::frame_s'(shift_r);
  assign frameShort = bitCount_r < quad_dac_pkg::FRAME_LEN;
  assign frameLong = (bitCount_r > quad_dac_pkg::FRAME_LEN) & ~chainMode_r;
  // in chain mode the last 24 bits shifted in are this device's word
  assign frameValid = ~frameShort & ~frameLong;
  assign writeFrame = frameEnd & frameValid & ~frame.readNotWrite;
  assign readArm = frameEnd & frameValid & frame.readNotWrite;
  assign clearCmd = writeFrame && (frame.registerSelectBits == quad_dac_pkg::REG_CTRL) &&
                    (frame.channelAddressBits == quad_dac_pkg::CTRL_CLEAR);
  assign clearing = clearPinLow | clearCmd;
  assign clearCode = clearSel_r ? quad_dac_pkg::CODE_MID : quad_dac_pkg::CODE_ZERO;

  // readback source; channel field picks the channel, data bits are ignored
  always_comb begin
    readWord = '0;
    unique case (frame.registerSelectBits)
      quad_dac_pkg::REG_DAC: readWord = dacReg_r[frame.channelAddressBits[1:0]];
      quad_dac_pkg::REG_RANGE: readWord = {13'h0000, range_r[frame.channelAddressBits[1:0]]};
      quad_dac_pkg::REG_POWER: readWord = {12'h000, powered_r};
      quad_dac_pkg::REG_CTRL: readWord = {13'h0000, clearSel_r, 1'b0, sdoOff_r};
      default: readWord = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // input shift register and serial output
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_r <= '0;
      bitCount_r <= '0;
    end else if (frameStart) begin
      bitCount_r <= '0;
    end else if (selLow && sclkFall) begin
      shift_r <= {shift_r[quad_dac_pkg::FRAME_BITS-2:0],
                  pinS2_r[quad_dac_pkg::PIN_SERIAL_DATA_IN]};
      if (bitCount_r != quad_dac_pkg::COUNT_MAX) begin
        bitCount_r <= bitCount_r + 5'd1;
      end
    end else if (readArm) begin
      // preload so the next frame shifts the selected register out msb first
      shift_r <= {shift_r[23:16], readWord};
    end
  end

  // shifting halts whenever select is high, so the latched word stays put
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sdo_r <= 1'b0;
    end else if (frameStart) begin
      // msb shows from select fall, so the first falling clock can capture it
      sdo_r <= shift_r[quad_dac_pkg::FRAME_BITS-1];
    end else if (selLow && sclkRise) begin
      sdo_r <= shift_r[quad_dac_pkg::FRAME_BITS-1];
    end
  end

  // output stays enabled from the read request through the following frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readOut_r <= 1'b0;
      sdoEn_r <= 1'b0;
    end else begin
      if (frameEnd) begin
        readOut_r <= readArm;
      end
      sdoEn_r <= ~sdoOff_r | readOut_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers reached through the link
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      powered_r <= '0;
      sdoOff_r <= 1'b0;
      clearSel_r <= 1'b0;
    end else if (writeFrame) begin
      unique case (frame.registerSelectBits)
        quad_dac_pkg::REG_POWER: begin
          powered_r <= frame.dataFieldBits[CHANNELS-1:0];
        end
        quad_dac_pkg::REG_CTRL: begin
          if (frame.channelAddressBits == quad_dac_pkg::CTRL_CONFIG) begin
            sdoOff_r <= frame.dataFieldBits[quad_dac_pkg::CFG_SDO_OFF_POS];
            clearSel_r <= frame.dataFieldBits[quad_dac_pkg::CFG_CLEAR_SEL_POS];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per channel input, converter and range registers
  // ----------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : gChan
      logic hit;
      logic dataWr;
      logic [DATA_W-1:0] stored;

      assign hit = chanHit(frame.channelAddressBits, gc);
      assign dataWr = writeFrame && hit && powered_r[gc] &&
                      (frame.registerSelectBits == quad_dac_pkg::REG_DAC);
      assign stored = toStored(frame.dataFieldBits, range_r[gc], twosSel);

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          range_r[gc] <= '0;
        end else if (writeFrame && hit &&
                     (frame.registerSelectBits == quad_dac_pkg::REG_RANGE)) begin
          range_r[gc] <= frame.dataFieldBits[2:0];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          inputReg_r[gc] <= '0;
        end else if (dataWr) begin
          inputReg_r[gc] <= stored;
        end
      end

      // clear outranks every update and holds while the pin is low
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          dacReg_r[gc] <= '0;
        end else if (clearing) begin
          dacReg_r[gc] <= clearCode;
        end else if (dataWr && loadLow) begin
          dacReg_r[gc] <= stored;
        end else if (loadFall && !selLow) begin
          dacReg_r[gc] <= inputReg_r[gc];
        end
      end

      assign dacCode[gc] = dacReg_r[gc];
      assign channelRange[gc] = range_r[gc];
    end
  endgenerate

  assign channelPowered = powered_r;
  assign serialDataOut = sdo_r;
  assign serialDataOutEn = sdoEn_r;

  // ----------------------------------------------------------------
  // apb slave: one wait state, registered answer
  // ----------------------------------------------------------------
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic access;
  logic commit;
  logic mapped;
  logic [31:0] rdMux;
  logic [11:0] addr;

  assign addr = apbReq.paddr;
  assign access = apbReq.psel & apbReq.penable;
  assign commit = access & pready_r;

  always_comb begin
    rdMux = quad_dac_pkg::WORD_ZERO;
    mapped = 1'b1;
    if (addr == quad_dac_pkg::OFF_LINK_CFG) begin
      rdMux[quad_dac_pkg::CFG_CHAIN_POS] = chainMode_r;
    end else if (addr == quad_dac_pkg::OFF_STATUS) begin
      rdMux[quad_dac_pkg::ST_SHORT_POS] = badShort_r;
      rdMux[quad_dac_pkg::ST_LONG_POS] = badLong_r;
      rdMux[quad_dac_pkg::ST_CLEAR_POS] = clearPinLow;
      rdMux[quad_dac_pkg::ST_READ_POS] = readOut_r;
    end else if (addr == quad_dac_pkg::OFF_POWER) begin
      rdMux[CHANNELS-1:0] = powered_r;
    end else if (addr == quad_dac_pkg::OFF_RANGE) begin
      rdMux[11:0] = {range_r[3], range_r[2], range_r[1], range_r[0]};
    end else if (addr >= quad_dac_pkg::OFF_DAC0 && addr <= quad_dac_pkg::OFF_DAC3 &&
                 addr[1:0] == 2'b00) begin
      rdMux[DATA_W-1:0] = dacReg_r[addr[3:2]];
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= quad_dac_pkg::WORD_ZERO;
    end else begin
      pready_r <= access & ~pready_r;
      if (access && !pready_r) begin
        pslverr_r <= ~mapped;
        prdata_r <= apbReq.pwrite ? quad_dac_pkg::WORD_ZERO : rdMux;
      end else begin
        pslverr_r <= 1'b0;
        prdata_r <= quad_dac_pkg::WORD_ZERO;
      end
    end
  end

  assign apbRsp = '{prdata: prdata_r, pready: pready_r, pslverr: pslverr_r};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chainMode_r <= 1'b0;
    end else if (commit && apbReq.pwrite && addr == quad_dac_pkg::OFF_LINK_CFG) begin
      chainMode_r <= apbReq.pwdata[quad_dac_pkg::CFG_CHAIN_POS];
    end
  end

  // sticky frame errors, write one to clear; a new error in the same cycle wins
  logic stWr;
  assign stWr = commit && apbReq.pwrite && addr == quad_dac_pkg::OFF_STATUS;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      badShort_r <= 1'b0;
      badLong_r <= 1'b0;
    end else begin
      if (frameEnd && frameShort) begin
        badShort_r <= 1'b1;
      end else if (stWr && apbReq.pwdata[quad_dac_pkg::ST_SHORT_POS]) begin
        badShort_r <= 1'b0;
      end
      if (frameEnd && frameLong) begin
        badLong_r <= 1'b1;
      end else if (stWr && apbReq.pwdata[quad_dac_pkg::ST_LONG_POS]) begin
        badLong_r <= 1'b0;
      end
    end
  end

endmodule : quad_dac_serial_load_control

// ==== quad_dac_props.sv ====
// concurrent checks on the pins and apb response of the serial load control
// assumes one sys_clk domain; bound to the top module, sees only its ports
`timescale 1ns/1ps
module quad_dac_props #(
  parameter int CHANNELS = 4,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic frameSelectN,
  input wire logic serialClk,
  input wire logic outputClearN,
  input wire quad_dac_pkg::apb_req_s apbReq,
  input wire quad_dac_pkg::apb_rsp_s apbRsp,
  input wire logic serialDataOut,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] dacCode,
  input wire logic [CHANNELS-1:0] channelPowered,
  input wire logic [CHANNELS-1:0][2:0] channelRange
);
  // ------------------------------------------------------------
  // helper: cycles inside a frame with the clear pin released
  // ------------------------------------------------------------
  logic [2:0] quietCnt_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || frameSelectN || !outputClearN) begin
      quietCnt_r <= 3'h0;
    end else if (quietCnt_r != 3'h7) begin
      quietCnt_r <= quietCnt_r + 3'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_RST_ZERO: assert property (
    $fell(sys_rst) |-> dacCode == '0 && channelPowered == '0 && channelRange == '0)
    else $error("registers not cleared by reset");
  AST_APB_WAIT: assert property (
    apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable |=> apbRsp.pready)
    else $error("access phase not two cycles");
  AST_READY_SCOPE: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
    else $error("ready outside access phase");
  AST_READY_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held too long");
  AST_ERR_EMPTY: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == '0)
    else $error("error response malformed");
  AST_OUT_EDGE: assert property (
    $fell(serialClk) && !frameSelectN |=> $stable(serialDataOut)[*2])
    else $error("serial output moved near falling clock");
  AST_LATCH_RISE: assert property (
    $changed({channelRange, channelPowered}) && !$past(apbReq.psel)
      |-> $past(frameSelectN) && $past(frameSelectN, 2))
    else $error("register changed without select rise");
  AST_QUIET_HOLD: assert property (
    quietCnt_r >= 3'h4 && !$past(apbReq.psel) |-> $stable(dacCode))
    else $error("codes changed inside a frame");
  AST_CLEAR_HOLD: assert property (
    (!outputClearN)[*7] |-> $stable(dacCode)
      && (dacCode == '0 || dacCode == {CHANNELS{quad_dac_pkg::CODE_MID}}))
    else $error("codes not held at clear level");
endmodule : quad_dac_props

bind quad_dac_serial_load_control quad_dac_props #(.CHANNELS(CHANNELS), .DATA_W(DATA_W))
  quad_dac_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .frameSelectN(frameSelectN),
  .serialClk(serialClk), .outputClearN(outputClearN), .apbReq(apbReq), .apbRsp(apbRsp),
  .serialDataOut(serialDataOut), .dacCode(dacCode), .channelPowered(channelPowered),
  .channelRange(channelRange));

// ==== quad_dac_host.sv ====
// host side of the serial link: frames bits out and captures the serial output
// assumes sys_clk of 40 ns; link clock period is eight sys_clk, idle high
`timescale 1ns/1ps
module quad_dac_host (
  input wire logic sys_clk,
  input wire logic serialDataOut,
  output logic frameSelectN,
  output logic serialClk,
  output logic serialDataIn,
  output logic [71:0] captured
);
  initial begin
    frameSelectN = 1'h1;
    serialClk = 1'h1;
    serialDataIn = 1'h0;
    captured = '0;
  end
  // ------------------------------------------------------------
  // one frame, word right aligned, nBits sent msb first
  // ------------------------------------------------------------
  // gated burst: the clock stands still high outside frames
  task automatic send(input logic [71:0] word, input int nBits);
    frameSelectN <= 1'h0;
    serialDataIn <= word[nBits-1];
    for (int i = nBits - 1; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      serialClk <= 1'h0;
      captured <= {captured[70:0], serialDataOut};
      repeat (4) @(posedge sys_clk);
      serialClk <= 1'h1;
      // released data line shows the inverse, never a stale copy
      if (i > 0) serialDataIn <= word[i-1];
      else serialDataIn <= ~word[0];
    end
    repeat (4) @(posedge sys_clk);
    frameSelectN <= 1'h1;
    repeat (8) @(posedge sys_clk);
  endtask : send
endmodule : quad_dac_host

// ==== quad_dac_serial_load_control_tb.sv ====
// directed bench: apb master tasks plus a host model on the serial link
// assumes the design package is compiled first and the checker is bound
`timescale 1ns/1ps
module quad_dac_serial_load_control_tb;
  logic sys_clk, sys_rst, loadOutputsN, outputClearN, codingSelectPin;
  logic frameSelectN, serialClk, serialDataIn, serialDataOut, serialDataOutEn;
  quad_dac_pkg::apb_req_s apbReq;
  quad_dac_pkg::apb_rsp_s apbRsp;
  logic [3:0][15:0] dacCode;
  logic [3:0] channelPowered;
  logic [3:0][2:0] channelRange;
  logic [71:0] captured;
  logic [31:0] rdData;
  logic rdErr;
  int badCount, checksDone;

  quad_dac_serial_load_control quad_dac_serial_load_control_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .frameSelectN(frameSelectN), .serialClk(serialClk),
    .serialDataIn(serialDataIn), .loadOutputsN(loadOutputsN), .outputClearN(outputClearN),
    .codingSelectPin(codingSelectPin), .apbReq(apbReq), .apbRsp(apbRsp),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn), .dacCode(dacCode),
    .channelPowered(channelPowered), .channelRange(channelRange));
  quad_dac_host quad_dac_host_i (.sys_clk(sys_clk), .serialDataOut(serialDataOut),
    .frameSelectN(frameSelectN), .serialClk(serialClk), .serialDataIn(serialDataIn),
    .captured(captured));

  always #20 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [23:0] mk(input logic rw, input logic [2:0] rs,
                                     input logic [2:0] ch, input logic [15:0] d);
    return {rw, 1'h0, rs, ch, d};
  endfunction : mk
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apbReq.penable <= 1'h1;
    do @(posedge sys_clk); while (apbRsp.pready !== 1'h1);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, '0);
    chk("apb read", exp, rdData);
  endtask : rd
  task automatic frame(input logic [23:0] w);
    quad_dac_host_i.send({48'h0, w}, 24);
  endtask : frame
  task automatic finalReport();
    if (badCount == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finalReport
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    {loadOutputsN, outputClearN, codingSelectPin} = 3'h2;
    apbReq = '0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    chk("reset codes", '0, {dacCode, channelPowered, channelRange});
    rd(quad_dac_pkg::OFF_POWER, 32'h0);
    apb(1'h0, 12'h100, '0);
    chk("unmapped error", 1'h1, rdErr);
    frame(mk(1'h0, 3'h0, 3'h0, 16'h1234));
    chk("write while down", '0, dacCode);
    frame(mk(1'h0, 3'h1, 3'h4, 16'h0000));
    frame(mk(1'h0, 3'h2, 3'h0, 16'h000F));
    chk("power", 4'hF, channelPowered);
    frame(mk(1'h0, 3'h0, 3'h0, 16'h1234));
    chk("individual", 16'h1234, dacCode[0]);
    loadOutputsN <= 1'h1;
    frame(mk(1'h0, 3'h0, 3'h1, 16'hBEEF));
    frame(mk(1'h0, 3'h0, 3'h2, 16'h0101));
    chk("held", 16'h0, dacCode[1]);
    loadOutputsN <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk("simultaneous", 48'h0101_BEEF_1234, dacCode[2:0]);
    quad_dac_host_i.send({48'h0, mk(1'h0, 3'h0, 3'h0, 16'h5555)}, 20);
    rd(quad_dac_pkg::OFF_STATUS, 32'h0000_0001);
    apb(1'h1, quad_dac_pkg::OFF_STATUS, 32'h0000_0001);
    quad_dac_host_i.send({47'h0, mk(1'h0, 3'h0, 3'h0, 16'h5555), 1'h0}, 25);
    rd(quad_dac_pkg::OFF_STATUS, 32'h0000_0002);
    chk("bad frames dropped", 16'h1234, dacCode[0]);
    apb(1'h1, quad_dac_pkg::OFF_LINK_CFG, 32'h0000_0001);
    quad_dac_host_i.send({24'h0, mk(1'h0, 3'h0, 3'h1, 16'h7777),
                          mk(1'h0, 3'h0, 3'h0, 16'h4321)}, 48);
    chk("chain keeps last", 32'hBEEF_4321, dacCode[1:0]);
    chk("chain passes first", mk(1'h0, 3'h0, 3'h1, 16'h7777), captured[23:0]);
    apb(1'h1, quad_dac_pkg::OFF_LINK_CFG, 32'h0000_0000);
    frame(mk(1'h0, 3'h3, 3'h1, 16'h0001));
    chk("out disabled", 1'h0, serialDataOutEn);
    frame(24'h80_5A5A);
    chk("out on for read", 1'h1, serialDataOutEn);
    frame(quad_dac_pkg::NO_OPERATION_FRAME);
    chk("readback", 32'h4321_4321, {captured[15:0], dacCode[0]});
    chk("out off again", 1'h0, serialDataOutEn);
    codingSelectPin <= 1'h1;
    frame(mk(1'h0, 3'h1, 3'h3, 16'h0003));
    chk("range", 3'h3, channelRange[3]);
    frame(mk(1'h0, 3'h0, 3'h3, 16'h0001));
    frame(mk(1'h0, 3'h0, 3'h0, 16'h0001));
    chk("coding", 32'h8001_0001, {dacCode[3], dacCode[0]});
    frame(mk(1'h0, 3'h3, 3'h1, 16'h0004));
    outputClearN <= 1'h0;
    repeat (8) @(posedge sys_clk);
    chk("clear mid", {4{16'h8000}}, dacCode);
    frame(mk(1'h0, 3'h0, 3'h0, 16'h9999));
    chk("update blocked", {4{16'h8000}}, dacCode);
    outputClearN <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk("clear holds", {4{16'h8000}}, dacCode);
    frame(mk(1'h0, 3'h3, 3'h1, 16'h0000));
    frame(mk(1'h0, 3'h0, 3'h2, 16'h2222));
    frame(mk(1'h0, 3'h3, 3'h4, 16'h0000));
    chk("clear command", '0, dacCode);
    finalReport();
  end
  // about 4300 cycles of traffic; seven times that means a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    badCount++;
    finalReport();
  end
endmodule : quad_dac_serial_load_control_tb
